// File: src/fbep_pkg.sv
// package with sizes, encodings and carrier types for the flash erase and protection logic
package fbep_pkg;
   localparam int ADDR_W = 18;
   localparam int WORD_W = 32;
   localparam int WORD_BYTES = 4;
   localparam int FLASH_BYTES = 262144;
   localparam int BLOCK_BYTES = 1024;
   localparam int UNIT_BYTES = 2048;
   localparam int WORD_IDX_W = 16;
   localparam int NUM_WORDS = FLASH_BYTES / WORD_BYTES;
   localparam int WORDS_PER_BLOCK = BLOCK_BYTES / WORD_BYTES;
   localparam int NUM_BLOCKS = FLASH_BYTES / BLOCK_BYTES;
   localparam int NUM_UNITS = FLASH_BYTES / UNIT_BYTES;
   localparam int BLOCK_LSB = 10;
   localparam int UNIT_LSB = 11;
   localparam int WORD_LSB = 2;
   localparam int BLK_W = 8;
   localparam int UNIT_W = 7;
   localparam int OFS_W = 8;
   localparam logic [WORD_W-1:0] ERASED_WORD = 32'hffffffff;
   localparam logic [OFS_W-1:0] OFS_LAST = 8'hff;

   typedef enum logic [1:0] {
      FBEP_PROT_OPEN = 2'h0,
      FBEP_PROT_RDONLY = 2'h1,
      FBEP_PROT_XONLY = 2'h2
   } fbep_prot_t;

   typedef enum logic [1:0] {
      FBEP_OP_FETCH = 2'h0,
      FBEP_OP_DREAD = 2'h1,
      FBEP_OP_PROG = 2'h2,
      FBEP_OP_ERASE = 2'h3
   } fbep_op_t;

   typedef enum logic [1:0] {
      FBEP_SRC_CPU = 2'h0,
      FBEP_SRC_DBG = 2'h1
   } fbep_src_t;

   typedef enum logic [1:0] {
      FBEP_ST_IDLE = 2'h0,
      FBEP_ST_ERASE = 2'h1,
      FBEP_ST_DONE = 2'h3
   } fbep_state_t;

   typedef struct packed {
      fbep_op_t op;
      fbep_src_t src;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } fbep_req_t;

   typedef struct packed {
      logic ok;
      logic denied;
      logic [WORD_W-1:0] rdata;
   } fbep_rsp_t;

   typedef struct packed {
      logic we;
      logic [UNIT_W-1:0] unit;
      fbep_prot_t prot;
   } fbep_cfg_t;
endpackage

// File: src/fbep_flash_ctrl.sv
// flash array with block erase and per-unit read-only / execute-only protection
`timescale 1ns/1ps
// Operation
// - the array holds 256 KB addressed as one contiguous byte space of 32-bit words.
// - the array is split into 1 KB blocks, each erasable alone without touching others.
// - once a block erase completes every bit in that block reads as one.
// - block pairs form 2 KB units, each with its own independent protection setting.
// - a read-only unit refuses erase and program but still serves reads.
// - an execute-only unit refuses erase, program and data reads, serving only fetches.
module fbep_flash_ctrl (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   input wire logic req_valid_in,
   input wire fbep_pkg::fbep_req_t req_in,
   output logic req_ready_out,
   input wire fbep_pkg::fbep_cfg_t cfg_in,
   output logic rsp_valid_out,
   output fbep_pkg::fbep_rsp_t rsp_out,
   output logic busy_out
);
   // array storage, one entry per 32-bit word; contents are not reset
   logic [fbep_pkg::WORD_W-1:0] mem_q [fbep_pkg::NUM_WORDS];
   // protection setting of every 2 KB unit
   fbep_pkg::fbep_prot_t prot_q [fbep_pkg::NUM_UNITS];
   fbep_pkg::fbep_state_t state_q;
   logic [fbep_pkg::BLK_W-1:0] eblk_q;
   logic [fbep_pkg::OFS_W-1:0] eofs_q;
   logic rsp_valid_q;
   fbep_pkg::fbep_rsp_t rsp_q;
   logic [fbep_pkg::UNIT_W-1:0] req_unit;
   logic [fbep_pkg::BLK_W-1:0] req_blk;
   logic [fbep_pkg::WORD_IDX_W-1:0] req_widx;
   logic [fbep_pkg::WORD_IDX_W-1:0] erase_widx;
   fbep_pkg::fbep_prot_t req_prot;
   logic is_fetch;
   logic is_dread;
   logic is_prog;
   logic is_erase;
   logic in_erase;
   logic in_done;
   logic erase_last;
   logic allow;
   logic take;
   logic start_erase;
   logic start_prog;

   // word index over the whole array, no holes
   assign req_widx = req_in.addr[fbep_pkg::ADDR_W-1:fbep_pkg::WORD_LSB];
   assign req_blk = req_in.addr[fbep_pkg::ADDR_W-1:fbep_pkg::BLOCK_LSB];
   // the unit index drops the block-in-pair bit so both halves share a setting
   assign req_unit = req_in.addr[fbep_pkg::ADDR_W-1:fbep_pkg::UNIT_LSB];
   assign req_prot = prot_q[req_unit];
   assign erase_widx = {eblk_q, eofs_q};

   // operation class of the request on the port
   assign is_fetch = (req_in.op == fbep_pkg::FBEP_OP_FETCH);
   assign is_dread = (req_in.op == fbep_pkg::FBEP_OP_DREAD);
   assign is_prog = (req_in.op == fbep_pkg::FBEP_OP_PROG);
   assign is_erase = (req_in.op == fbep_pkg::FBEP_OP_ERASE);

   // sequencer status
   assign in_erase = (state_q == fbep_pkg::FBEP_ST_ERASE);
   assign in_done = (state_q == fbep_pkg::FBEP_ST_DONE);
   assign erase_last = (eofs_q == fbep_pkg::OFS_LAST);

   // requests are only taken while no erase is running
   assign req_ready_out = (state_q == fbep_pkg::FBEP_ST_IDLE);
   assign take = clk_en_in && req_valid_in && req_ready_out;
   assign start_erase = take && allow && is_erase;
   assign start_prog = take && allow && is_prog;
   assign busy_out = (state_q != fbep_pkg::FBEP_ST_IDLE);
   assign rsp_valid_out = rsp_valid_q;
   assign rsp_out = rsp_q;

   // permission check; the source plays no part, so core and debugger
   // data reads are judged alike
   always_comb begin
      allow = 1'b1;
      case (req_prot)
         fbep_pkg::FBEP_PROT_RDONLY: begin
            case (req_in.op)
               fbep_pkg::FBEP_OP_FETCH: begin
                  allow = 1'b1;
               end
               fbep_pkg::FBEP_OP_DREAD: begin
                  allow = 1'b1;
               end
               fbep_pkg::FBEP_OP_PROG: begin
                  allow = 1'b0;
               end
               fbep_pkg::FBEP_OP_ERASE: begin
                  allow = 1'b0;
               end
               default: begin
                  allow = 1'b0;
               end
            endcase
         end
         fbep_pkg::FBEP_PROT_XONLY: begin
            case (req_in.op)
               fbep_pkg::FBEP_OP_FETCH: begin
                  allow = 1'b1;
               end
               fbep_pkg::FBEP_OP_DREAD: begin
                  allow = 1'b0;
               end
               fbep_pkg::FBEP_OP_PROG: begin
                  allow = 1'b0;
               end
               fbep_pkg::FBEP_OP_ERASE: begin
                  allow = 1'b0;
               end
               default: begin
                  allow = 1'b0;
               end
            endcase
         end
         default: begin
            allow = 1'b1;
         end
      endcase
   end

   // protection table: each entry listens only to writes of its own index
   for (genvar u = 0; u < fbep_pkg::NUM_UNITS; u++) begin : g_unit
      logic wr_sel;
      assign wr_sel = cfg_in.we && (cfg_in.unit == fbep_pkg::UNIT_W'(u));
      always_ff @(posedge sys_clk_in) begin
         if (srst_in) begin
            prot_q[u] <= fbep_pkg::FBEP_PROT_OPEN;
         end else if (clk_en_in && wr_sel) begin
            prot_q[u] <= cfg_in.prot;
         end
      end
   end

   // erase sequencer walks every word of one block only
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         state_q <= fbep_pkg::FBEP_ST_IDLE;
         eblk_q <= '0;
         eofs_q <= '0;
      end else if (clk_en_in) begin
         case (state_q)
            fbep_pkg::FBEP_ST_IDLE: begin
               if (start_erase) begin
                  state_q <= fbep_pkg::FBEP_ST_ERASE;
                  eblk_q <= req_blk;
                  eofs_q <= '0;
               end
            end
            fbep_pkg::FBEP_ST_ERASE: begin
               if (erase_last) begin
                  state_q <= fbep_pkg::FBEP_ST_DONE;
               end else begin
                  eofs_q <= eofs_q + 8'h01;
               end
            end
            fbep_pkg::FBEP_ST_DONE: begin
               state_q <= fbep_pkg::FBEP_ST_IDLE;
            end
            default: begin
               state_q <= fbep_pkg::FBEP_ST_IDLE;
            end
         endcase
      end
   end

   // array writes: erase sets ones, program clears bits only
   always_ff @(posedge sys_clk_in) begin
      if (clk_en_in) begin
         if (in_erase) begin
            mem_q[erase_widx] <= fbep_pkg::ERASED_WORD;
         end else if (start_prog) begin
            mem_q[req_widx] <= mem_q[req_widx] & req_in.wdata;
         end
      end
   end

   // one response per accepted request; a permitted erase answers when the block is done, a refused one at once
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         rsp_valid_q <= 1'b0;
         rsp_q <= '0;
      end else if (clk_en_in) begin
         rsp_valid_q <= 1'b0;
         if (in_done) begin
            rsp_valid_q <= 1'b1;
            rsp_q <= '{ok: 1'b1, denied: 1'b0, rdata: '0};
         end else if (take) begin
            if (!allow) begin
               // refused requests never show array contents
               rsp_valid_q <= 1'b1;
               rsp_q <= '{ok: 1'b0, denied: 1'b1, rdata: '0};
            end else if (!is_erase) begin
               rsp_valid_q <= 1'b1;
               rsp_q.ok <= 1'b1;
               rsp_q.denied <= 1'b0;
               if (is_prog) begin
                  rsp_q.rdata <= '0;
               end else if (is_fetch || is_dread) begin
                  rsp_q.rdata <= mem_q[req_widx];
               end else begin
                  rsp_q.rdata <= '0;
               end
            end
         end
      end
   end
endmodule // fbep_flash_ctrl

// File: verif/fbep_checker.sv
// port assertions for the flash erase and protection controller
`timescale 1ns/1ps
module fbep_checker (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic clk_en_in,
   input wire logic req_valid_in,
   input wire fbep_pkg::fbep_req_t req_in,
   input wire logic req_ready_out,
   input wire fbep_pkg::fbep_cfg_t cfg_in,
   input wire logic rsp_valid_out,
   input wire fbep_pkg::fbep_rsp_t rsp_out,
   input wire logic busy_out
);
   wire tk = clk_en_in && req_valid_in && req_ready_out;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   a_fetch_served: assert property (tk && req_in.op == fbep_pkg::FBEP_OP_FETCH |=>
      rsp_valid_out && rsp_out.ok) else $error("fetch not served");
   a_read_answer: assert property (tk && req_in.op != fbep_pkg::FBEP_OP_ERASE |=>
      rsp_valid_out) else $error("no answer after one cycle");
   a_erase_start: assert property (tk && req_in.op == fbep_pkg::FBEP_OP_ERASE |=>
      busy_out || (rsp_valid_out && rsp_out.denied)) else $error("erase not started");
   a_erase_length: assert property ($rose(busy_out) |-> ##257
      (rsp_valid_out && rsp_out.ok)) else $error("erase length wrong");
   a_busy_no_take: assert property (busy_out |-> !req_ready_out)
      else $error("ready during erase");
   a_ok_xor_denied: assert property (rsp_valid_out |-> rsp_out.ok != rsp_out.denied)
      else $error("ok and denied clash");
   a_deny_no_data: assert property (rsp_valid_out && rsp_out.denied |->
      rsp_out.rdata == '0) else $error("denied response leaks data");
   a_rsp_stands: assert property (!rsp_valid_out |-> $stable(rsp_out))
      else $error("response changed without valid");
endmodule // fbep_checker
bind fbep_flash_ctrl fbep_checker u_chk (.sys_clk_in(sys_clk_in), .srst_in(srst_in),
   .clk_en_in(clk_en_in), .req_valid_in(req_valid_in), .req_in(req_in),
   .req_ready_out(req_ready_out), .cfg_in(cfg_in), .rsp_valid_out(rsp_valid_out),
   .rsp_out(rsp_out), .busy_out(busy_out));

// File: verif/fbep_host_model.sv
// requester model: holds a request until the controller takes it
`timescale 1ns/1ps
module fbep_host_model (
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic go_in,
   input wire fbep_pkg::fbep_req_t cmd_in,
   input wire logic ready_in,
   output logic valid_out,
   output fbep_pkg::fbep_req_t req_out
);
   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         valid_out <= 1'b0;
         req_out <= '0;
      end else if (valid_out && ready_in) begin
         valid_out <= 1'b0;
         req_out <= ~req_out;
      end else if (go_in) begin
         valid_out <= 1'b1;
         req_out <= cmd_in;
      end
   end
endmodule // fbep_host_model

// File: verif/flash_block_erase_protect_tb.sv
// self-checking bench for the flash erase and protection controller
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_fail++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module flash_block_erase_protect_tb;
   localparam logic [1:0] FE = 2'h0, RD = 2'h1, PG = 2'h2, ER = 2'h3;
   logic clk = 1'b0, rst = 1'b1, go = 1'b0, en = 1'b1, rv, rdy, rsp, busy;
   fbep_pkg::fbep_req_t cmd = '0, req;
   fbep_pkg::fbep_cfg_t cfg = '0;
   fbep_pkg::fbep_rsp_t r;
   int n_fail = 0, tests_run = 0;
   always #10 clk = ~clk;
   fbep_host_model host (.sys_clk_in(clk), .srst_in(rst), .go_in(go), .cmd_in(cmd),
      .ready_in(rdy), .valid_out(rv), .req_out(req));
   fbep_flash_ctrl dut (.sys_clk_in(clk), .srst_in(rst), .clk_en_in(en), .req_valid_in(rv),
      .req_in(req), .req_ready_out(rdy), .cfg_in(cfg), .rsp_valid_out(rsp), .rsp_out(r),
      .busy_out(busy));
   task automatic op(input logic [1:0] o, input logic [17:0] a, input logic [31:0] d = '0,
      input logic [1:0] s = 2'h0);
      int i;
      @(negedge clk);
      cmd = '{fbep_pkg::fbep_op_t'(o), fbep_pkg::fbep_src_t'(s), a, d};
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      for (i = 0; i < 300 && rsp !== 1'b1; i++) @(negedge clk);
      `CHK(rsp, 1'b1)
   endtask
   task automatic freeze_cfg();
      @(negedge clk);
      en = 1'b0;
      cfg = '{1'b1, 7'h2, fbep_pkg::FBEP_PROT_RDONLY};
      @(negedge clk);
      cfg.we = 1'b0;
      en = 1'b1;
      `CHK(busy, 1'b0)
   endtask
   task automatic mid_reset();
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK({busy, rdy, rsp}, 3'h2)
   endtask
   task automatic prot(input logic [6:0] u, input fbep_pkg::fbep_prot_t p);
      @(negedge clk);
      cfg = '{1'b1, u, p};
      @(negedge clk);
      cfg.we = 1'b0;
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #200us;
      n_fail++;
      conclude();
   end
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      op(ER, 18'h0); `CHK(r.ok, 1'b1)
      op(RD, 18'h3fc); `CHK(r.rdata, fbep_pkg::ERASED_WORD)
      op(PG, 18'h4, 32'h12345678);
      op(ER, 18'h400);
      op(RD, 18'h4); `CHK(r.rdata, 32'h12345678)
      op(RD, 18'h7fc); `CHK(r.rdata, fbep_pkg::ERASED_WORD)
      op(ER, 18'h3fc00);
      op(RD, 18'h3fffc); `CHK(r.rdata, fbep_pkg::ERASED_WORD)
      prot(7'h0, fbep_pkg::FBEP_PROT_RDONLY);
      op(ER, 18'h400); `CHK({r.ok, r.denied}, 2'h1)
      op(PG, 18'h4, 32'h0); `CHK({r.ok, r.denied}, 2'h1)
      op(RD, 18'h4); `CHK(r.rdata, 32'h12345678)
      op(ER, 18'hc00);
      prot(7'h1, fbep_pkg::FBEP_PROT_XONLY);
      op(FE, 18'hc00); `CHK(r.rdata, fbep_pkg::ERASED_WORD)
      op(RD, 18'h800); `CHK({r.ok, r.denied}, 2'h1)
      op(RD, 18'hc04, 32'h0, 2'h1); `CHK(r.rdata, 32'h0)
      op(ER, 18'hc00); `CHK({r.ok, r.denied}, 2'h1)
      op(ER, 18'h1000); `CHK(r.ok, 1'b1)
      freeze_cfg();
      op(ER, 18'h1400); `CHK({r.ok, r.denied}, 2'h2)
      mid_reset();
      op(RD, 18'h800); `CHK({r.ok, r.denied}, 2'h2)
      conclude();
   end
endmodule // flash_block_erase_protect_tb
